// >>> dv/fragmented_socket_mailbox_test.sv
// Bench: drives mailbox commands over APB, checks answers and socket bytes.
// Assumes the socket model on the receive side; the bench drives transmit room, ample first and then one byte.
`timescale 1ns/10ps
module fragmented_socket_mailbox_test;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, load = 0;
  logic pready, pslverr, txValid, txLast, rxValid, rxLast, rxAvail, rxClosed, rxReady;
  logic [7:0] paddr = 0, cnt = 0, txData, rxData;
  logic [31:0] pwdata = 0, prdata, rv, m, seed = 45;
  logic [12:0] txRoom = 13'h1000;
  logic [33:0] rdQ[$];
  logic [7:0] txQ[$];
  int fails = 0, num_checks = 0, cyc = 0;
  fsmb_top dut(.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txRoom(txRoom), .txValid(txValid), .txData(txData), .txLast(txLast), .rxValid(rxValid),
    .rxData(rxData), .rxLast(rxLast), .rxAvail(rxAvail), .rxClosed(rxClosed), .rxReady(rxReady));
  fsmb_sock_model sock(.clk(clk), .sys_rst(sys_rst), .load(load), .count(cnt), .rxReady(rxReady),
    .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxAvail(rxAvail), .rxClosed(rxClosed));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************
  // Result monitor
  // ****************
  always @(posedge clk) begin : mon
    logic [33:0] e;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
    if (txValid === 1'b1) cmp({24'h0, txData}, {24'h0, txQ.pop_front()});
    if (psel && penable && pready === 1'b1) begin
      e = rdQ.pop_front();
      cmp({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) cmp(prdata, e[31:0]);
    end
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [33:0] e);
    @(posedge clk);
    rdQ.push_back(e);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1, d, 34'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 0, 0, {2'b10, e});
  endtask
  task automatic go(input logic [15:0] c, input logic [15:0] ft, input int n, input logic [31:0] rq);
    logic [7:0] b;
    m = rnd();
    m[31:16] = 16'h0;
    wr(fsmb_pkg::A_MSGID, m);
    wr(fsmb_pkg::A_CMD, {16'h0, c});
    wr(fsmb_pkg::A_DSIZE, 32'(n));
    wr(fsmb_pkg::A_SOCK, 32'h7);
    wr(fsmb_pkg::A_FTYPE, {16'h0, ft});
    wr(fsmb_pkg::A_REQSZ, rq);
    for (int i = 0; i < n; i++) begin
      b = 8'(rnd());
      txQ.push_back(b);
      wr(fsmb_pkg::A_TXDATA, {24'h0, b});
    end
    wr(fsmb_pkg::A_CTRL, 32'h1);
    rv = 0;
    for (int i = 0; i < 200 && !rv[1]; i++) apb(fsmb_pkg::A_STATUS, 0, 0, 34'h0);
  endtask
  task automatic ld(input logic [7:0] c);
    cnt <= c;
    load <= 1;
    @(posedge clk);
    load <= 0;
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    go(fsmb_pkg::CMD_SEND, fsmb_pkg::FT_MID, 0, 0);
    rdc(fsmb_pkg::A_RSPFLT, {16'h0, fsmb_pkg::FLT_SEQ});
    rdc(fsmb_pkg::A_RSPINFO, {16'h0, fsmb_pkg::INFO_RSP});
    rdc(fsmb_pkg::A_RSPMSG, m);
    go(fsmb_pkg::CMD_SEND, fsmb_pkg::FT_FIRST, 2, 0);
    rdc(fsmb_pkg::A_RSPW3, 32'h0);
    rdc(fsmb_pkg::A_RSPW2, {16'h0, fsmb_pkg::FT_FIRST});
    cmp(32'(txQ.size()), 32'h2);
    go(fsmb_pkg::CMD_SEND, fsmb_pkg::FT_LAST, 1, 0);
    rdc(fsmb_pkg::A_RSPW3, 32'h3);
    rdc(fsmb_pkg::A_RSPW1, 32'h7);
    cmp(32'(txQ.size()), 32'h0);
    // Room for one byte only, so the non-blocking send stops short
    txRoom <= 13'h0001;
    go(fsmb_pkg::CMD_SEND, fsmb_pkg::FT_FIRST, 2, 0);
    go(fsmb_pkg::CMD_SEND, fsmb_pkg::FT_LAST, 1, 0);
    rdc(fsmb_pkg::A_RSPW3, 32'h1);
    cmp(32'(txQ.size()), 32'h2);
    txQ.delete();
    ld(8'h03);
    go(fsmb_pkg::CMD_RECV, fsmb_pkg::FT_FIRST, 0, 3);
    rdc(fsmb_pkg::A_RSPSIZE, 32'h3);
    rdc(fsmb_pkg::A_RSPW3, 32'h0);
    for (int i = 3; i > 0; i--) rdc(fsmb_pkg::A_RXDATA, 32'h50 + i);
    go(fsmb_pkg::CMD_RECV, fsmb_pkg::FT_FIRST, 0, 3);
    rdc(fsmb_pkg::A_RSPSIZE, 32'h0);
    wr(fsmb_pkg::A_CFG, 32'h1);
    ld(8'h05);
    go(fsmb_pkg::CMD_RECV, fsmb_pkg::FT_FIRST, 0, 3);
    rdc(fsmb_pkg::A_RSPSIZE, 32'h3);
    for (int i = 5; i > 2; i--) rdc(fsmb_pkg::A_RXDATA, 32'h50 + i);
    go(fsmb_pkg::CMD_RECV, fsmb_pkg::FT_MID, 0, 9);
    rdc(fsmb_pkg::A_RSPSIZE, 32'h0);
    rdc(fsmb_pkg::A_RSPW2, {16'h0, fsmb_pkg::FT_MID});
    // Blocking from here on; each blocked command is released by a close
    wr(fsmb_pkg::A_CFG, 32'h2);
    go(fsmb_pkg::CMD_RECV, fsmb_pkg::FT_FIRST, 0, 3);
    rdc(fsmb_pkg::A_STATUS, 32'h1);
    wr(fsmb_pkg::A_CTRL, 32'h0007_0002);
    rdc(fsmb_pkg::A_RSPFLT, {16'h0, fsmb_pkg::FLT_ABORT});
    ld(8'h00);
    go(fsmb_pkg::CMD_RECV, fsmb_pkg::FT_FIRST, 0, 3);
    rdc(fsmb_pkg::A_RSPSIZE, 32'h0);
    rdc(fsmb_pkg::A_RSPFLT, {16'h0, fsmb_pkg::FLT_NONE});
    go(fsmb_pkg::CMD_SEND, fsmb_pkg::FT_FIRST, 1, 0);
    go(fsmb_pkg::CMD_SEND, fsmb_pkg::FT_LAST, 1, 0);
    rdc(fsmb_pkg::A_STATUS, 32'h5);
    cmp(32'(txQ.size()), 32'h2);
    wr(fsmb_pkg::A_CTRL, 32'h0007_0002);
    rdc(fsmb_pkg::A_RSPFLT, {16'h0, fsmb_pkg::FLT_ABORT});
    apb(8'hFC, 0, 0, {2'b01, 32'h0});
    tally_and_finish;
  end
endmodule

// >>> dv/fsmb_sock_model.sv
// Socket source model: offers a loaded count of bytes to the receive side.
// Assumes the bench pulses load for one cycle while idle; a load of zero marks the far end closed.
`timescale 1ns/10ps
module fsmb_sock_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [7:0] count,
  input wire logic rxReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxLast,
  output logic rxAvail,
  output logic rxClosed
);
  logic [7:0] left_r;
  logic [7:0] tog_r;
  logic closed_r;
  // Idle data toggles so a stale byte is never mistaken for a fresh one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_r <= 8'h00;
      tog_r <= 8'h00;
      closed_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (load) closed_r <= count == 8'h00;
      if (load) left_r <= count;
      else if (rxValid && rxReady) left_r <= left_r - 8'h01;
    end
  end
  assign rxValid = left_r != 8'h00;
  assign rxData = rxValid ? {4'h5, left_r[3:0]} : tog_r;
  assign rxLast = left_r == 8'h01;
  assign rxAvail = rxValid;
  assign rxClosed = closed_r;
endmodule

// >>> include/fsmb_buf_if.sv
// Port of one message buffer: a write port and a registered read port.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface fsmb_buf_if #(parameter int unsigned AW = 12);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [7:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [7:0] rdData;
  modport mem(input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
  modport user(output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
endinterface

// >>> include/fsmb_pkg.sv
// Constants, register map and state codes of the fragmented socket mailbox.
// Assumes nothing beyond a SystemVerilog compiler.
package fsmb_pkg;
  // ********************************
  // Sizes and protocol codes
  // ********************************
  localparam int unsigned MSG_DEPTH = 4096;
  localparam int unsigned ADR_W = 12;
  localparam logic [12:0] MSG_MAX = 13'h1000;
  localparam logic [12:0] FRAG_MAX = 13'h0100;
  localparam logic [15:0] CMD_SEND = 16'h005E;
  localparam logic [15:0] CMD_RECV = 16'h005F;
  localparam logic [15:0] INFO_RSP = 16'h0002;
  localparam logic [15:0] FRAME_ONE = 16'h0001;
  localparam logic [15:0] FT_FIRST = 16'h0000;
  localparam logic [15:0] FT_MID = 16'h0001;
  localparam logic [15:0] FT_LAST = 16'h0002;
  localparam logic [15:0] FLT_NONE = 16'h0000;
  localparam logic [15:0] FLT_SEQ = 16'h0001;
  localparam logic [15:0] FLT_SIZE = 16'h0002;
  localparam logic [15:0] FLT_CMD = 16'h0003;
  localparam logic [15:0] FLT_ABORT = 16'h0010;
  // ********************************
  // Register map and fields
  // ********************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MSGID = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_DSIZE = 8'h0C;
  localparam logic [7:0] A_SOCK = 8'h10;
  localparam logic [7:0] A_FTYPE = 8'h14;
  localparam logic [7:0] A_REQSZ = 8'h18;
  localparam logic [7:0] A_CFG = 8'h1C;
  localparam logic [7:0] A_TXDATA = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam logic [7:0] A_RSPMSG = 8'h28;
  localparam logic [7:0] A_RSPCMD = 8'h2C;
  localparam logic [7:0] A_RSPSIZE = 8'h30;
  localparam logic [7:0] A_RSPW1 = 8'h34;
  localparam logic [7:0] A_RSPW2 = 8'h38;
  localparam logic [7:0] A_RSPW3 = 8'h3C;
  localparam logic [7:0] A_RSPFLT = 8'h40;
  localparam logic [7:0] A_RXDATA = 8'h44;
  localparam logic [7:0] A_RSPINFO = 8'h48;
  localparam logic [7:0] A_RSPFRM = 8'h4C;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_CLOSE = 1;
  localparam int unsigned CFG_UDP = 0;
  localparam int unsigned CFG_BLOCK = 1;
  localparam logic [1:0] RST_CFG = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROOM = 3'b001,
    ST_TX = 3'b010,
    ST_RXWAIT = 3'b011,
    ST_RXFILL = 3'b100,
    ST_DELIV = 3'b101
  } fsmb_state_e;
endpackage

// >>> logic/fsmb_apb.sv
// APB handshake for the mailbox: one wait state on every access.
// Assumes a standard APB master on the same clock.
`timescale 1ns/10ps
module fsmb_apb (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic pready,
  output logic wrEv,
  output logic rdEv
);
  logic pready_r;

  // Wait state gives the read mux a full cycle to settle into a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel && penable && !pready_r;
    end
  end

  assign pready = pready_r;
  assign wrEv = psel && penable && pready_r && pwrite;
  assign rdEv = psel && penable && pready_r && !pwrite;
endmodule

// >>> logic/fsmb_buf.sv
// Byte buffer holding one whole fragmented message.
// Assumes the user keeps addresses below DEPTH.
`timescale 1ns/10ps
module fsmb_buf #(
  parameter int unsigned DEPTH = 4096,
  parameter int unsigned AW = 12
) (
  input wire logic clk,
  fsmb_buf_if.mem bp
);
  logic [7:0] mem [DEPTH];

  // No reset: contents are only read below the stored length
  always_ff @(posedge clk) begin
    if (bp.wrEn) begin
      mem[bp.wrAddr] <= bp.wrData;
    end
    bp.rdData <= mem[bp.rdAddr];
  end
endmodule

// >>> logic/fsmb_top.sv
// Fragmented socket mailbox: APB command registers, send reassembly,
// receive buffering and piecewise delivery of the buffered message.
// Assumes one clock; the socket sink takes every offered byte, the
// socket source obeys valid/ready.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module fsmb_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [12:0] txRoom,
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  input wire logic rxAvail,
  input wire logic rxClosed,
  output logic rxReady
);
  // ********************************
  // Storage
  // ********************************
  fsmb_pkg::fsmb_state_e state_r, state_nxt;
  logic [15:0] msgId_r, cmd_r, dsize_r, sock_r, ftype_r, reqSize_r;
  logic [1:0] cfg_r;
  logic [8:0] stage_r, fragLeft_r;
  logic [12:0] txLen_r, txAmt_r, txIdx_r;
  logic [12:0] rxLen_r, rxWr_r, rxNext_r, rxReq_r;
  logic [11:0] rxPtr_r;
  logic sendOn_r, txPend_r, txPendLast_r, rxReady_r;
  logic txValid_r, txLast_r, pslverr_r;
  logic [7:0] txData_r;
  logic [31:0] prdata_r, rdMux;
  logic rdHit;
  logic rspValid_r;
  logic [15:0] rspMsg_r, rspCmd_r, rspSize_r, rspW1_r, rspW2_r, rspW3_r, rspFault_r;
  logic rspEv;
  logic [15:0] rspSize, rspW3, rspFault;
  logic wrEv, rdEv;

  fsmb_buf_if #(.AW(fsmb_pkg::ADR_W)) txBus();
  fsmb_buf_if #(.AW(fsmb_pkg::ADR_W)) rxBus();

  fsmb_apb uApb (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .wrEv(wrEv),
    .rdEv(rdEv)
  );
  // Buffers sized for a full message
  fsmb_buf #(.DEPTH(fsmb_pkg::MSG_DEPTH), .AW(fsmb_pkg::ADR_W)) uTxBuf (.clk(clk), .bp(txBus.mem));
  fsmb_buf #(.DEPTH(fsmb_pkg::MSG_DEPTH), .AW(fsmb_pkg::ADR_W)) uRxBuf (.clk(clk), .bp(rxBus.mem));

  // ********************************
  // Decode
  // ********************************
  wire idle = state_r == fsmb_pkg::ST_IDLE;
  // Header is locked while a command runs, so echoes stay stable
  wire wrHit = wrEv && idle;
  wire wrCtrl = wrEv && paddr == fsmb_pkg::A_CTRL;
  wire go = wrCtrl && pwdata[fsmb_pkg::CTRL_GO] && idle;
  wire closeEv = wrCtrl && pwdata[fsmb_pkg::CTRL_CLOSE] && pwdata[31:16] == sock_r;
  wire udp = cfg_r[fsmb_pkg::CFG_UDP];
  wire blocking = cfg_r[fsmb_pkg::CFG_BLOCK];
  wire isSend = cmd_r == fsmb_pkg::CMD_SEND;
  wire isRecv = cmd_r == fsmb_pkg::CMD_RECV;
  wire ftFirst = ftype_r == fsmb_pkg::FT_FIRST;
  wire ftMid = ftype_r == fsmb_pkg::FT_MID;
  wire ftLast = ftype_r == fsmb_pkg::FT_LAST;
  wire [12:0] txBase = ftFirst ? 13'h0000 : txLen_r;
  wire [12:0] stageEnd = txBase + {4'h0, stage_r};
  wire [12:0] sendTot = txBase + {4'h0, dsize_r[8:0]};
  wire seqBad = !(ftFirst || ftMid || ftLast) || (!ftFirst && !sendOn_r);
  wire sizeBad = dsize_r > {3'h0, fsmb_pkg::FRAG_MAX} || sendTot > fsmb_pkg::MSG_MAX
    || {7'h00, stage_r} != dsize_r;
  wire stageWr = wrHit && paddr == fsmb_pkg::A_TXDATA && stage_r < fsmb_pkg::FRAG_MAX[8:0]
    && stageEnd < fsmb_pkg::MSG_MAX;
  wire roomOk = txRoom >= txLen_r;
  wire txIssue = txIdx_r != txAmt_r;
  wire txDone = !txIssue && !txPend_r;
  wire rxAny = rxValid || rxAvail;
  wire rxFull = rxWr_r == rxReq_r;
  // TCP never takes beyond the request
  wire rxTake = rxValid && rxReady_r && (udp || !rxFull);
  // Datagram bytes past the request are taken and dropped
  wire rxWrite = rxTake && !rxFull;
  wire [12:0] rxCnt = rxWr_r + {12'h000, rxWrite};
  // Stop at the count or when the stream runs dry
  wire tcpDone = rxFull || (rxWrite && rxCnt == rxReq_r) || !rxAny;
  wire fillDone = udp ? (rxTake && rxLast) : tcpDone;
  // Size word read only for a first fragment
  wire [12:0] reqClip = reqSize_r > {3'h0, fsmb_pkg::MSG_MAX} ? fsmb_pkg::MSG_MAX : reqSize_r[12:0];
  wire [12:0] rxLeft = rxLen_r - rxNext_r;
  wire [12:0] fragN = rxLeft > fsmb_pkg::FRAG_MAX ? fsmb_pkg::FRAG_MAX : rxLeft;
  wire rxPop = rdEv && paddr == fsmb_pkg::A_RXDATA && fragLeft_r != 9'h000;

  assign txBus.wrEn = stageWr;
  assign txBus.wrAddr = stageEnd[11:0];
  assign txBus.wrData = pwdata[7:0];
  assign txBus.rdAddr = txIdx_r[11:0];
  assign rxBus.wrEn = rxWrite;
  assign rxBus.wrAddr = rxWr_r[11:0];
  assign rxBus.wrData = rxData;
  assign rxBus.rdAddr = rxPtr_r;

  // ********************************
  // Sequencer and answers
  // ********************************
  always_comb begin
    state_nxt = state_r;
    rspEv = 1'b0;
    rspSize = 16'h0000;
    rspW3 = 16'h0000;
    rspFault = fsmb_pkg::FLT_NONE;
    unique case (state_r)
      fsmb_pkg::ST_IDLE: begin
        if (go && isSend) begin
          rspSize = dsize_r;
          if (seqBad || sizeBad) begin
            rspEv = 1'b1;
            rspFault = seqBad ? fsmb_pkg::FLT_SEQ : fsmb_pkg::FLT_SIZE;
          end else if (ftLast) begin
            state_nxt = fsmb_pkg::ST_ROOM;
          end else begin
            rspEv = 1'b1;
          end
        end else if (go && isRecv) begin
          if (ftMid) begin
            state_nxt = fsmb_pkg::ST_DELIV;
          end else if (!ftFirst) begin
            rspEv = 1'b1;
            rspFault = fsmb_pkg::FLT_SEQ;
          end else if (rxAny) begin
            state_nxt = fsmb_pkg::ST_RXFILL;
          end else if (!blocking) begin
            rspEv = 1'b1;
          end else begin
            state_nxt = fsmb_pkg::ST_RXWAIT;
          end
        end else if (go) begin
          rspEv = 1'b1;
          rspFault = fsmb_pkg::FLT_CMD;
        end
      end
      fsmb_pkg::ST_ROOM: begin
        rspSize = dsize_r;
        if (closeEv) begin
          rspEv = 1'b1;
          rspFault = fsmb_pkg::FLT_ABORT;
          state_nxt = fsmb_pkg::ST_IDLE;
        // Non-blocking never waits; blocking holds here
        end else if (roomOk || !blocking) begin
          state_nxt = fsmb_pkg::ST_TX;
        end
      end
      fsmb_pkg::ST_TX: begin
        // Sent count only in the final answer
        if (txDone) begin
          rspEv = 1'b1;
          rspSize = dsize_r;
          rspW3 = {3'h0, txAmt_r};
          state_nxt = fsmb_pkg::ST_IDLE;
        end
      end
      fsmb_pkg::ST_RXWAIT: begin
        if (closeEv) begin
          rspEv = 1'b1;
          rspFault = fsmb_pkg::FLT_ABORT;
          state_nxt = fsmb_pkg::ST_IDLE;
        end else if (rxAny) begin
          state_nxt = fsmb_pkg::ST_RXFILL;
        // Remote close gives a zero answer
        end else if (rxClosed) begin
          rspEv = 1'b1;
          state_nxt = fsmb_pkg::ST_IDLE;
        end
      end
      fsmb_pkg::ST_RXFILL: begin
        // Whole message lands before any delivery
        if (fillDone) begin
          state_nxt = fsmb_pkg::ST_DELIV;
        end
      end
      fsmb_pkg::ST_DELIV: begin
        rspEv = 1'b1;
        rspSize = {3'h0, fragN};
        rspW3 = {3'h0, rxLeft - fragN};
        state_nxt = fsmb_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = fsmb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= fsmb_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ********************************
  // Command header
  // ********************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msgId_r <= 16'h0000;
      cmd_r <= 16'h0000;
      dsize_r <= 16'h0000;
      sock_r <= 16'h0000;
      ftype_r <= 16'h0000;
      reqSize_r <= 16'h0000;
      cfg_r <= fsmb_pkg::RST_CFG;
    end else if (wrHit) begin
      if (paddr == fsmb_pkg::A_MSGID) msgId_r <= pwdata[15:0];
      if (paddr == fsmb_pkg::A_CMD) cmd_r <= pwdata[15:0];
      if (paddr == fsmb_pkg::A_DSIZE) dsize_r <= pwdata[15:0];
      if (paddr == fsmb_pkg::A_SOCK) sock_r <= pwdata[15:0];
      if (paddr == fsmb_pkg::A_FTYPE) ftype_r <= pwdata[15:0];
      if (paddr == fsmb_pkg::A_REQSZ) reqSize_r <= pwdata[15:0];
      if (paddr == fsmb_pkg::A_CFG) cfg_r <= pwdata[1:0];
    end
  end

  // ********************************
  // Send assembly and transmit
  // ********************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage_r <= 9'h000;
      txLen_r <= 13'h0000;
      sendOn_r <= 1'b0;
      txAmt_r <= 13'h0000;
      txIdx_r <= 13'h0000;
      txPend_r <= 1'b0;
      txPendLast_r <= 1'b0;
    end else begin
      stage_r <= go ? 9'h000 : stage_r + {8'h00, stageWr};
      if (go && isSend && !seqBad && !sizeBad) begin
        txLen_r <= sendTot;
        sendOn_r <= 1'b1;
      end
      // Short room sends only what fits
      if (state_r == fsmb_pkg::ST_ROOM && state_nxt == fsmb_pkg::ST_TX) begin
        txAmt_r <= roomOk ? txLen_r : txRoom;
        txIdx_r <= 13'h0000;
      end else if (state_r == fsmb_pkg::ST_TX && txIssue) begin
        txIdx_r <= txIdx_r + 13'h0001;
      end
      txPend_r <= state_r == fsmb_pkg::ST_TX && txIssue;
      txPendLast_r <= state_r == fsmb_pkg::ST_TX && txIssue && txIdx_r == txAmt_r - 13'h0001;
      if ((state_r == fsmb_pkg::ST_TX && txDone) || (state_r == fsmb_pkg::ST_ROOM && closeEv)) begin
        sendOn_r <= 1'b0;
      end
    end
  end

  // Read latency of the buffer is one cycle, so the stream trails the index by two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txValid_r <= 1'b0;
      txData_r <= 8'h00;
      txLast_r <= 1'b0;
    end else begin
      txValid_r <= txPend_r;
      txData_r <= txPend_r ? txBus.rdData : 8'h00;
      txLast_r <= txPendLast_r;
    end
  end

  // ********************************
  // Receive buffer
  // ********************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxReady_r <= 1'b0;
      rxWr_r <= 13'h0000;
      rxReq_r <= 13'h0000;
      rxLen_r <= 13'h0000;
      rxNext_r <= 13'h0000;
      rxPtr_r <= 12'h000;
      fragLeft_r <= 9'h000;
    end else begin
      rxReady_r <= state_nxt == fsmb_pkg::ST_RXFILL;
      if (go && isRecv && ftFirst) begin
        rxWr_r <= 13'h0000;
        rxReq_r <= reqClip;
        rxLen_r <= 13'h0000;
        rxNext_r <= 13'h0000;
        fragLeft_r <= 9'h000;
      end else if (state_r == fsmb_pkg::ST_RXFILL) begin
        rxWr_r <= rxCnt;
        if (fillDone) rxLen_r <= rxCnt;
      // Next fragment from the buffered message
      end else if (state_r == fsmb_pkg::ST_DELIV) begin
        rxPtr_r <= rxNext_r[11:0];
        rxNext_r <= rxNext_r + fragN;
        fragLeft_r <= fragN[8:0];
      end else if (rxPop) begin
        rxPtr_r <= rxPtr_r + 12'h001;
        fragLeft_r <= fragLeft_r - 9'h001;
      end
    end
  end

  // ********************************
  // Answer registers
  // ********************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rspValid_r <= 1'b0;
      rspMsg_r <= 16'h0000;
      rspCmd_r <= 16'h0000;
      rspSize_r <= 16'h0000;
      rspW1_r <= 16'h0000;
      rspW2_r <= 16'h0000;
      rspW3_r <= 16'h0000;
      rspFault_r <= fsmb_pkg::FLT_NONE;
    end else begin
      rspValid_r <= rspEv || (rspValid_r && !go);
      // Echo identifier and command; echo socket and type
      if (rspEv) begin
        rspMsg_r <= msgId_r;
        rspCmd_r <= cmd_r;
        rspSize_r <= rspSize;
        rspW1_r <= sock_r;
        rspW2_r <= ftype_r;
        rspW3_r <= rspW3;
        rspFault_r <= rspFault;
      end
    end
  end

  // ********************************
  // APB read side
  // ********************************
  always_comb begin
    rdHit = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      fsmb_pkg::A_CTRL, fsmb_pkg::A_TXDATA: rdMux = 32'h0000_0000;
      fsmb_pkg::A_MSGID: rdMux = {16'h0000, msgId_r};
      fsmb_pkg::A_CMD: rdMux = {16'h0000, cmd_r};
      fsmb_pkg::A_DSIZE: rdMux = {16'h0000, dsize_r};
      fsmb_pkg::A_SOCK: rdMux = {16'h0000, sock_r};
      fsmb_pkg::A_FTYPE: rdMux = {16'h0000, ftype_r};
      fsmb_pkg::A_REQSZ: rdMux = {16'h0000, reqSize_r};
      fsmb_pkg::A_CFG: rdMux = {30'h0000_0000, cfg_r};
      fsmb_pkg::A_STATUS: rdMux = {7'h00, fragLeft_r, 13'h0000, sendOn_r, rspValid_r, !idle};
      fsmb_pkg::A_RSPMSG: rdMux = {16'h0000, rspMsg_r};
      fsmb_pkg::A_RSPCMD: rdMux = {16'h0000, rspCmd_r};
      fsmb_pkg::A_RSPSIZE: rdMux = {16'h0000, rspSize_r};
      fsmb_pkg::A_RSPW1: rdMux = {16'h0000, rspW1_r};
      fsmb_pkg::A_RSPW2: rdMux = {16'h0000, rspW2_r};
      fsmb_pkg::A_RSPW3: rdMux = {16'h0000, rspW3_r};
      fsmb_pkg::A_RSPFLT: rdMux = {16'h0000, rspFault_r};
      fsmb_pkg::A_RXDATA: rdMux = {24'h00_0000, fragLeft_r != 9'h000 ? rxBus.rdData : 8'h00};
      // Fixed answer information and frame words
      fsmb_pkg::A_RSPINFO: rdMux = {16'h0000, fsmb_pkg::INFO_RSP};
      fsmb_pkg::A_RSPFRM: rdMux = {fsmb_pkg::FRAME_ONE, fsmb_pkg::FRAME_ONE};
      default: rdHit = 1'b0;
    endcase
  end

  // Loaded in the first access cycle so both outputs come from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr_r <= !rdHit;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign txValid = txValid_r;
  assign txData = txData_r;
  assign txLast = txLast_r;
  assign rxReady = rxReady_r;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_tx_after_last: assert property (txValid_r |-> ftLast && sendOn_r)
    else $error("byte sent before final fragment");
  chk_msg_limit: assert property (txLen_r <= fsmb_pkg::MSG_MAX && rxLen_r <= fsmb_pkg::MSG_MAX)
    else $error("message length above limit");
  chk_nonblk_now: assert property (state_r == fsmb_pkg::ST_ROOM && !blocking && !closeEv
    |=> state_r == fsmb_pkg::ST_TX && txAmt_r <= $past(txLen_r))
    else $error("non-blocking send waited");
  chk_blk_hold: assert property (state_r == fsmb_pkg::ST_ROOM && blocking && !roomOk && !closeEv
    |=> state_r == fsmb_pkg::ST_ROOM && !rspValid_r)
    else $error("blocking send answered without room");
  chk_sent_final: assert property ($rose(rspValid_r) && rspCmd_r == fsmb_pkg::CMD_SEND
    && rspW2_r != fsmb_pkg::FT_LAST |-> rspW3_r == 16'h0000)
    else $error("sent count outside final answer");
  chk_udp_bound: assert property (state_r == fsmb_pkg::ST_RXFILL |-> rxWr_r <= rxReq_r)
    else $error("receive buffer passed request");
  chk_empty_zero: assert property (go && isRecv && ftFirst && !blocking && !rxAny
    |=> rspValid_r && rspSize_r == 16'h0000 && idle)
    else $error("empty non-blocking receive not answered");
  chk_frag_cap: assert property ($rose(rspValid_r) && rspCmd_r == fsmb_pkg::CMD_RECV
    |-> rspSize_r <= {3'h0, fsmb_pkg::FRAG_MAX} && fragLeft_r == rspSize_r[8:0])
    else $error("receive fragment too long");
  chk_abort_code: assert property (closeEv && state_r == fsmb_pkg::ST_RXWAIT
    |=> rspValid_r && rspFault_r == fsmb_pkg::FLT_ABORT ##1 idle)
    else $error("blocked receive not aborted");
  chk_seq_reject: assert property (go && isSend && !ftFirst && !sendOn_r
    |=> rspFault_r == fsmb_pkg::FLT_SEQ && !sendOn_r)
    else $error("orphan continuation accepted");
endmodule
